// ---- lsd_config_decoder.sv ----
// Purpose: Command decoder and configuration state of an LCD driver
// Assumes: Bytes from the serial receiver; PWM levels from same clock
// Notes:   RAM streams only advance the write pointers here
//
// Summary of operation
// - First byte bit is one for opcodes, zero for parameter bytes.
// - Opcode 81h takes a mode parameter; fields reset to 00h.
// - Display off grounds outputs and stops supplies at frame boundary.
// - Display on starts supplies and scans display RAM continuously.
// - General and LED outputs ignore display on or off.
// - Mode bit 2 picks line inversion; bits 1:0 pick power mode.
// - Opcode 82h sets duty in bits 3:2; parameter resets to 02h.
// - Third duty ignores common 3 data and mirrors common 1.
// - Frame divider from bits 1:0 and duty; reset code is 10.
// - Opcode 83h loads display RAM start address; 31h is dummy.
// - Opcode 84h bit 2 enables blink; bits 1:0 pick the rate.
// - Opcode 87h loads blink RAM start address; 31h is dummy.
// - Opcode 88h turns the top N selectable pins into outputs.
// - General output drives supply level when its data bit is high.
// - Reassigned pins leave RAM addressing unchanged.
// - Opcode 89h bit 2 selects 8-bit PWM resolution, else 12-bit.
// - Opcode 89h bits 1:0 give up to three open-drain LED pins.
// - Inhibit low forces general outputs and PWM low, LEDs float.
// - After reset all pins are segments and PWM output is low.
// - Bytes shift MSB first; raising select drops a partial byte.
// - After a RAM or output-data opcode, bytes are data until reselect.
`timescale 1ns/10ps
module lsd_config_decoder #(
    parameter int OSC_CYC = lsd_pkg::OSC_CYC
) (
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        chip_select_n_in,
    input  wire logic        serial_clock_in,
    input  wire logic        serial_input_in,
    input  wire logic        output_inhibit_n_in,
    input  wire logic        pwm1_level_in,
    input  wire logic        pwm2_level_in,
    output logic             display_on_out,
    output logic             line_inversion_out,
    output logic [1:0]       power_mode_out,
    output logic [1:0]       duty_out,
    output logic             com3_mirror_out,
    output logic [9:0]       frame_div_out,
    output logic             frame_tick_out,
    output logic             blink_enable_out,
    output logic [1:0]       blink_rate_out,
    output logic [5:0]       display_ram_addr_out,
    output logic [5:0]       blink_ram_addr_out,
    output logic             pwm_8bit_out,
    output logic [30:0]      gpo_select_out,
    output logic [30:0]      gpo_level_out,
    output logic [2:0]       led_select_out,
    output logic [2:0]       led_sink_en_out,
    output logic             pwm_output_pin_out
);
    typedef struct packed {
        lsd_pkg::lsd_dec_t st;
        logic [7:0]  op;
        logic [7:0]  mode;
        logic [7:0]  duty;
        logic [7:0]  dadr;
        logic [7:0]  blink;
        logic [7:0]  badr;
        logic [7:0]  gcnt;
        logic [7:0]  led;
        logic [31:0] gdat;
        logic [1:0]  gidx;
        logic [5:0]  dptr;
        logic [5:0]  bptr;
        logic        disp_on;
        logic [2:0]  inh_s;
        logic        inh;
        logic [30:0] gsel;
        logic [30:0] glvl;
        logic [2:0]  lsel;
        logic [2:0]  lsink;
        logic        pwm;
    } lsd_dec_s_t;

    localparam lsd_dec_s_t DEC_RST = '{
        st: lsd_pkg::DEC_IDLE, mode: lsd_pkg::RST_MODE,
        duty: lsd_pkg::RST_DUTY, dptr: lsd_pkg::ADDR_FIRST,
        bptr: lsd_pkg::ADDR_FIRST, default: '0};

    lsd_link_if lk ();

    lsd_serial_rx u_rx (
        .clk_in           (clk_in),
        .sys_rst_in       (sys_rst_in),
        .chip_select_n_in (chip_select_n_in),
        .serial_clock_in  (serial_clock_in),
        .serial_input_in  (serial_input_in),
        .lk               (lk.rx)
    );

    lsd_frame_timer #(.OSC_CYC(OSC_CYC)) u_tmr (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .lk         (lk.tmr)
    );

    ////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [9:0] frame_divider(input logic [7:0] p);
        logic [9:0] d;
        d = lsd_pkg::DIV_Q2;
        if (p[3]) begin
            case (p[1:0])
                2'b00:   d = lsd_pkg::DIV_S0;
                2'b01:   d = lsd_pkg::DIV_S1;
                2'b10:   d = lsd_pkg::DIV_S2;
                default: d = lsd_pkg::DIV_S3;
            endcase
        end else if (p[2]) begin
            case (p[1:0])
                2'b00:   d = lsd_pkg::DIV_T0;
                2'b01:   d = lsd_pkg::DIV_T1;
                2'b10:   d = lsd_pkg::DIV_T2;
                default: d = lsd_pkg::DIV_T3;
            endcase
        end else begin
            case (p[1:0])
                2'b00:   d = lsd_pkg::DIV_Q0;
                2'b01:   d = lsd_pkg::DIV_Q1;
                2'b10:   d = lsd_pkg::DIV_Q2;
                default: d = lsd_pkg::DIV_Q3;
            endcase
        end
        return d;
    endfunction

    // Pointer moves one 4-bit location; the dummy slot wraps to the start
    function automatic logic [5:0] addr_inc(input logic [5:0] a);
        return (a >= lsd_pkg::ADDR_DUMMY) ? lsd_pkg::ADDR_FIRST
                                          : a + 6'h01;
    endfunction

    function automatic logic two_byte_op(input logic [7:0] o);
        return o == lsd_pkg::OP_DRIVE_MODE || o == lsd_pkg::OP_DUTY_FRAME
            || o == lsd_pkg::OP_DISP_ADDR  || o == lsd_pkg::OP_BLINK_RATE
            || o == lsd_pkg::OP_BLINK_ADDR || o == lsd_pkg::OP_GPO_ASSIGN
            || o == lsd_pkg::OP_LED_ASSIGN;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Decoder state

    lsd_dec_s_t r;
    lsd_dec_s_t next_r;
    logic [7:0] d;

    always_comb begin
        next_r = r;
        d      = lk.byte_data;
        if (lk.byte_stb) begin
            if (r.st == lsd_pkg::DEC_DATA) begin
                if (r.op == lsd_pkg::OP_GPO_DATA) begin
                    next_r.gdat[{r.gidx, 3'h0} +: 8] = d;
                    if (r.gidx != 2'h3) next_r.gidx = r.gidx + 2'h1;
                end else if (r.op == lsd_pkg::OP_RAM_WRITE) begin
                    next_r.dptr = addr_inc(addr_inc(r.dptr));
                end else begin
                    next_r.bptr = addr_inc(addr_inc(r.bptr));
                end
            end else if (d[lsd_pkg::DC_BIT]) begin
                next_r.op = d;
                next_r.st = lsd_pkg::DEC_IDLE;
                if (two_byte_op(d)) begin
                    next_r.st = lsd_pkg::DEC_PARAM;
                end else if (d == lsd_pkg::OP_RAM_WRITE
                          || d == lsd_pkg::OP_BLINK_WRITE
                          || d == lsd_pkg::OP_GPO_DATA) begin
                    next_r.st   = lsd_pkg::DEC_DATA;
                    next_r.gidx = 2'h0;
                end else if (d == lsd_pkg::OP_SOFT_RESET) begin
                    next_r = DEC_RST;
                end
            end else if (r.st == lsd_pkg::DEC_PARAM) begin
                next_r.st = lsd_pkg::DEC_IDLE;
                case (r.op)
                    lsd_pkg::OP_DRIVE_MODE: next_r.mode = {4'h0, d[3:0]};
                    lsd_pkg::OP_DUTY_FRAME: next_r.duty = {4'h0, d[3:0]};
                    lsd_pkg::OP_DISP_ADDR: begin
                        next_r.dadr = {2'h0, d[5:0]};
                        next_r.dptr = d[5:0];
                    end
                    lsd_pkg::OP_BLINK_RATE: next_r.blink = {5'h0, d[2:0]};
                    lsd_pkg::OP_BLINK_ADDR: begin
                        next_r.badr = {2'h0, d[5:0]};
                        next_r.bptr = d[5:0];
                    end
                    lsd_pkg::OP_GPO_ASSIGN: next_r.gcnt = {3'h0, d[4:0]};
                    lsd_pkg::OP_LED_ASSIGN: next_r.led = {5'h0, d[2:0]};
                    default: next_r.st = lsd_pkg::DEC_IDLE;
                endcase
            end
        end
        if (lk.cs_rise && r.st == lsd_pkg::DEC_DATA) begin
            next_r.st = lsd_pkg::DEC_IDLE;
        end

        // Turning on is immediate; turning off waits for the frame end
        if (r.mode[lsd_pkg::MODE_ON_BIT]) begin
            next_r.disp_on = 1'b1;
        end else if (lk.frame_tick) begin
            next_r.disp_on = 1'b0;
        end

        // Inhibit pin synchroniser and filter
        next_r.inh_s = {r.inh_s[1:0], output_inhibit_n_in};
        if (r.inh_s[1] == r.inh_s[2]) next_r.inh = r.inh_s[2];

        // Pin assignment and levels, independent of display state
        for (int i = 0; i < lsd_pkg::GPO_PINS; i++) begin
            next_r.gsel[i] = 32'(i) >= 32'(lsd_pkg::GPO_PINS)
                                     - 32'(r.gcnt[4:0]);
            next_r.glvl[i] = next_r.gsel[i] && r.inh
                          && r.gdat[lsd_pkg::GPO_PINS - 1 - i];
        end
        for (int k = 0; k < lsd_pkg::LED_PINS; k++) begin
            next_r.lsel[k]  = 32'(r.led[1:0]) > 32'(k);
            next_r.lsink[k] = next_r.lsel[k] && r.inh
                && ((k == 0) ? pwm1_level_in : pwm2_level_in);
        end
        next_r.pwm = r.inh && pwm2_level_in;
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) r <= DEC_RST;
        else            r <= next_r;
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    assign lk.osc_run   = r.mode[lsd_pkg::MODE_ON_BIT] | r.disp_on;
    assign lk.frame_div = frame_divider(r.duty);

    assign display_on_out       = r.disp_on;
    assign line_inversion_out   = r.mode[lsd_pkg::MODE_INV_BIT];
    assign power_mode_out       = r.mode[1:0];
    assign duty_out             = r.duty[3:2];
    assign com3_mirror_out      = r.duty[3:2] == lsd_pkg::DUTY_THIRD;
    assign frame_div_out        = lk.frame_div;
    assign frame_tick_out       = lk.frame_tick;
    assign blink_enable_out     = r.blink[lsd_pkg::BLINK_EN_BIT];
    assign blink_rate_out       = r.blink[lsd_pkg::BLINK_EN_BIT]
                                  ? r.blink[1:0] : 2'h0;
    assign display_ram_addr_out = r.dptr;
    assign blink_ram_addr_out   = r.bptr;
    assign pwm_8bit_out         = r.led[lsd_pkg::RES8_BIT];
    assign gpo_select_out       = r.gsel;
    assign gpo_level_out        = r.glvl;
    assign led_select_out       = r.lsel;
    assign led_sink_en_out      = r.lsink;
    assign pwm_output_pin_out   = r.pwm;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    chk_param_flag: assert property (
        lk.byte_stb && !lk.byte_data[7] && r.st == lsd_pkg::DEC_IDLE
        |=> r.st == lsd_pkg::DEC_IDLE && $stable(r.mode))
        else $error("data byte taken as command");

    chk_mode_load: assert property (
        lk.byte_stb && !lk.byte_data[7] && r.st == lsd_pkg::DEC_PARAM
        && r.op == lsd_pkg::OP_DRIVE_MODE
        |=> r.mode[3:0] == $past(lk.byte_data[3:0]))
        else $error("mode parameter not stored");

    chk_off_frame: assert property (
        r.disp_on && !r.mode[lsd_pkg::MODE_ON_BIT] && !lk.frame_tick
        |=> r.disp_on)
        else $error("display turned off between frames");

    chk_on_fast: assert property (
        $rose(r.mode[lsd_pkg::MODE_ON_BIT]) |=> display_on_out)
        else $error("display did not turn on");

    chk_addr_wrap: assert property (
        lk.byte_stb && r.st == lsd_pkg::DEC_DATA
        && r.op == lsd_pkg::OP_RAM_WRITE && r.dptr == lsd_pkg::ADDR_LAST
        |=> r.dptr == lsd_pkg::ADDR_FIRST)
        else $error("display pointer did not wrap via dummy");

    chk_gpo_none: assert property (
        r.gcnt == 8'h00 ##1 r.gcnt == 8'h00 |-> gpo_select_out == 31'h0)
        else $error("pin reassigned with zero count");

    chk_led_count: assert property (
        r.led[1:0] == 2'h1 ##1 r.led[1:0] == 2'h1
        |-> led_select_out == 3'h1)
        else $error("wrong LED pin selection");

    chk_inhibit_low: assert property (
        !r.inh [*2] |-> gpo_level_out == 31'h0 && !pwm_output_pin_out
                        && led_sink_en_out == 3'h0)
        else $error("outputs active while inhibited");

    chk_data_hold: assert property (
        r.st == lsd_pkg::DEC_DATA && lk.byte_stb && !lk.cs_rise
        |=> r.st == lsd_pkg::DEC_DATA)
        else $error("command accepted in data mode");

    chk_soft_reset: assert property (
        lk.byte_stb && r.st != lsd_pkg::DEC_DATA
        && lk.byte_data == lsd_pkg::OP_SOFT_RESET
        |=> r.gcnt == 8'h00 && r.led == 8'h00 && r.dptr == 6'h00
            && r.duty == lsd_pkg::RST_DUTY)
        else $error("soft reset left configuration");

    cov_off_cycle: cover property (
        display_on_out && !r.mode[lsd_pkg::MODE_ON_BIT] && lk.frame_tick
        ##1 !display_on_out);
    cov_soft_reset: cover property (
        lk.byte_stb && r.st != lsd_pkg::DEC_DATA
        && lk.byte_data == lsd_pkg::OP_SOFT_RESET);
    cov_led_one: cover property (led_select_out == 3'h1);
    cov_ram_wrap: cover property (
        r.dptr == lsd_pkg::ADDR_LAST ##1 r.dptr == lsd_pkg::ADDR_FIRST);
    cov_gpo_data: cover property (
        r.st == lsd_pkg::DEC_DATA && r.op == lsd_pkg::OP_GPO_DATA
        && lk.byte_stb);
endmodule

// ---- lsd_config_decoder_test.sv ----
// Purpose: Self-checking bench for the configuration decoder
// Assumes: Oscillator divider shortened to 4 clocks
// Notes:   Status is packed into one word per compare
`timescale 1ns/10ps
module lsd_config_decoder_test;
    logic        clk_in;
    logic        rst;
    logic        inh_n;
    logic        pwm1;
    logic        pwm2;
    logic        cs_n, sclk, sdat, on, linv, com3, blk, p8, pin, ftick;
    logic [1:0]  pm, duty, brate;
    logic [9:0]  fdiv;
    logic [5:0]  da, ba;
    logic [30:0] gsel, glvl;
    logic [2:0]  lsel, lsink;
    logic [31:0] cfg, ad;
    int          failures = 0;
    int          tests_run = 0;
    assign cfg = {15'h0, pin, lsink, on, linv, pm, duty, blk, brate, p8, lsel};
    assign ad  = {10'h0, fdiv, da, ba};
    always #20 clk_in = ~clk_in;
    lsd_host_model u_lsd_host_model (.clk_in(clk_in),
        .chip_select_n_out(cs_n), .serial_clock_out(sclk),
        .serial_input_out(sdat));
    lsd_config_decoder #(.OSC_CYC(4)) u_lsd_config_decoder (
        .clk_in(clk_in), .sys_rst_in(rst), .chip_select_n_in(cs_n),
        .serial_clock_in(sclk), .serial_input_in(sdat),
        .output_inhibit_n_in(inh_n), .pwm1_level_in(pwm1),
        .pwm2_level_in(pwm2), .display_on_out(on),
        .line_inversion_out(linv), .power_mode_out(pm), .duty_out(duty),
        .com3_mirror_out(com3), .frame_div_out(fdiv),
        .frame_tick_out(ftick), .blink_enable_out(blk),
        .blink_rate_out(brate), .display_ram_addr_out(da),
        .blink_ram_addr_out(ba), .pwm_8bit_out(p8),
        .gpo_select_out(gsel), .gpo_level_out(glvl),
        .led_select_out(lsel), .led_sink_en_out(lsink),
        .pwm_output_pin_out(pin));
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] op, input logic [7:0] p);
        u_lsd_host_model.frame_start();
        u_lsd_host_model.send(op, 8);
        u_lsd_host_model.send(p, 8);
        u_lsd_host_model.frame_end();
        u_lsd_host_model.tick(8);
    endtask
    task automatic wait_on(input logic v);
        int n;
        n = 0;
        while (on !== v && n < 4000) begin
            u_lsd_host_model.tick(1);
            n++;
        end
        chk(32'(on), 32'(v));
        if (n == 4000) begin
            summarize();
        end
    endtask
    task automatic wait_tick(output int n);
        n = 0;
        do begin
            u_lsd_host_model.tick(1);
            n++;
        end while (ftick !== 1'b1 && n < 2000);
        if (ftick !== 1'b1) begin
            failures++;
            $display("MISMATCH t=%0t no frame tick", $time);
            summarize();
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        int divs [12] = '{160, 240, 320, 400, 156, 237, 315, 393,
                          160, 320, 428, 640};
        int n;
        clk_in = 1'b0;
        rst = 1'b1;
        inh_n = 1'b1;
        pwm1 = 1'b0;
        pwm2 = 1'b0;
        repeat (2) @(posedge clk_in);
        #1 rst = 1'b0;
        u_lsd_host_model.tick(4);
        chk(cfg, 32'h0);
        chk(ad, 32'h0014_0000);
        chk({1'b0, gsel}, 32'h0);
        u_lsd_host_model.frame_start();
        u_lsd_host_model.send(8'h0F, 8);
        u_lsd_host_model.frame_end();
        u_lsd_host_model.frame_start();
        u_lsd_host_model.send(lsd_pkg::OP_DRIVE_MODE, 4);
        u_lsd_host_model.frame_end();
        cmd(8'h0F, 8'h0F);
        chk(cfg, 32'h0);
        $display("test refusals done");
        cmd(lsd_pkg::OP_DRIVE_MODE, 8'h0F);
        wait_on(1'b1);
        chk(cfg, 32'h1E00);
        for (int i = 0; i < 16; i++) begin
            cmd(lsd_pkg::OP_DUTY_FRAME, 8'(i));
            chk(32'(fdiv), divs[(i > 7 ? 8 + i % 4 : i)]);
            chk(32'(duty), 32'(i / 4));
            chk(32'(com3), 32'(i / 4 == 1));
        end
        cmd(lsd_pkg::OP_DUTY_FRAME, lsd_pkg::RST_DUTY);
        wait_tick(n);
        wait_tick(n);
        chk(32'(n), 32'(4 * 320));
        cmd(lsd_pkg::OP_DISP_ADDR, 8'h30);
        cmd(lsd_pkg::OP_BLINK_ADDR, 8'h31);
        chk(ad, 32'h0014_0C31);
        u_lsd_host_model.frame_start();
        u_lsd_host_model.send(lsd_pkg::OP_RAM_WRITE, 8);
        u_lsd_host_model.send(8'h5A, 8);
        u_lsd_host_model.send(8'hA5, 8);
        u_lsd_host_model.frame_end();
        u_lsd_host_model.frame_start();
        u_lsd_host_model.send(lsd_pkg::OP_BLINK_WRITE, 8);
        u_lsd_host_model.send(8'h3C, 8);
        u_lsd_host_model.frame_end();
        u_lsd_host_model.tick(8);
        chk(ad, 32'h0014_0081);
        cmd(lsd_pkg::OP_BLINK_RATE, 8'h07);
        chk(cfg, 32'h1E70);
        cmd(lsd_pkg::OP_BLINK_RATE, 8'h03);
        chk(cfg, 32'h1E00);
        $display("test config done");
        cmd(lsd_pkg::OP_GPO_ASSIGN, 8'h03);
        chk({1'b0, gsel}, 32'h7000_0000);
        cmd(lsd_pkg::OP_GPO_ASSIGN, 8'h1F);
        chk({1'b0, gsel}, 32'h7FFF_FFFF);
        cmd(lsd_pkg::OP_LED_ASSIGN, 8'h01);
        chk(cfg, 32'h1E01);
        cmd(lsd_pkg::OP_LED_ASSIGN, 8'h07);
        chk(cfg, 32'h1E0F);
        pwm1 = 1'b1;
        pwm2 = 1'b1;
        u_lsd_host_model.tick(3);
        chk(cfg, 32'h1FE0F);
        u_lsd_host_model.frame_start();
        u_lsd_host_model.send(lsd_pkg::OP_GPO_DATA, 8);
        u_lsd_host_model.send(8'h01, 8);
        u_lsd_host_model.send(lsd_pkg::OP_DRIVE_MODE, 8);
        u_lsd_host_model.send(8'h00, 8);
        u_lsd_host_model.frame_end();
        u_lsd_host_model.tick(8);
        chk({1'b0, glvl}, 32'h4040_8000);
        chk(cfg, 32'h1FE0F);
        inh_n = 1'b0;
        u_lsd_host_model.tick(8);
        chk({1'b0, glvl}, 32'h0);
        chk(cfg, 32'h1E0F);
        inh_n = 1'b1;
        u_lsd_host_model.tick(8);
        $display("test ports done");
        cmd(lsd_pkg::OP_DRIVE_MODE, 8'h00);
        wait_on(1'b0);
        chk(cfg, 32'h1E00F);
        chk({1'b0, glvl}, 32'h4040_8000);
        pwm1 = 1'b0;
        pwm2 = 1'b0;
        u_lsd_host_model.frame_start();
        u_lsd_host_model.send(lsd_pkg::OP_SOFT_RESET, 8);
        u_lsd_host_model.frame_end();
        u_lsd_host_model.tick(8);
        chk(cfg, 32'h0);
        chk(ad, 32'h0014_0000);
        chk({gsel, glvl[0]}, 32'h0);
        $display("test off and reset done");
        summarize();
    end
endmodule

// ---- lsd_frame_timer.sv ----
// Purpose: Oscillator enable and frame tick from the selected divider
// Assumes: Oscillator rate is an enable pulse derived from clk_in
// Notes:   Counters hold at zero while the oscillator is stopped
`timescale 1ns/10ps
module lsd_frame_timer #(
    parameter int OSC_CYC = lsd_pkg::OSC_CYC
) (
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    lsd_link_if.tmr   lk
);
    localparam int OW = $clog2(OSC_CYC);
    localparam logic [OW-1:0] OSC_LAST = OW'(OSC_CYC - 1);

    typedef struct packed {
        logic [OW-1:0] osc;
        logic [9:0]    fr;
        logic          tick;
    } lsd_tmr_t;

    lsd_tmr_t r;
    lsd_tmr_t next_r;

    always_comb begin
        next_r      = r;
        next_r.tick = 1'b0;
        if (!lk.osc_run) begin
            next_r.osc = '0;
            next_r.fr  = '0;
        end else if (r.osc == OSC_LAST) begin
            next_r.osc = '0;
            if (r.fr >= lk.frame_div - 10'h001) begin
                next_r.fr   = '0;
                next_r.tick = 1'b1;
            end else begin
                next_r.fr = r.fr + 10'h001;
            end
        end else begin
            next_r.osc = r.osc + OW'(1);
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) r <= '0;
        else            r <= next_r;
    end

    assign lk.frame_tick = r.tick;
endmodule

// ---- lsd_host_model.sv ----
// Purpose: Host end of the three-wire serial link
// Assumes: Paced by the system clock, four clocks per serial phase
// Notes:   Serial clock rests low; data line toggles when deselected
`timescale 1ns/10ps
module lsd_host_model (
    input  wire logic clk_in,
    output logic      chip_select_n_out,
    output logic      serial_clock_out,
    output logic      serial_input_out
);
    initial begin
        chip_select_n_out = 1'b1;
        serial_clock_out  = 1'b0;
        serial_input_out  = 1'b0;
    end
    ////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // Data set while the clock is low, taken on its rise
    task automatic send(input logic [7:0] b, input int nbits);
        for (int i = 7; i > 7 - nbits; i--) begin
            serial_input_out = b[i];
            tick(4);
            serial_clock_out = 1'b1;
            tick(4);
            serial_clock_out = 1'b0;
        end
    endtask
    task automatic frame_start();
        chip_select_n_out = 1'b0;
        tick(4);
    endtask
    // Deselect ends data mode; the released data line stops holding
    task automatic frame_end();
        tick(4);
        chip_select_n_out = 1'b1;
        serial_input_out  = ~serial_input_out;
        tick(4);
    endtask
endmodule

// ---- lsd_link_if.sv ----
// Purpose: Carries bytes and frame timing between decoder sub-blocks
// Assumes: All signals on the system clock
// Notes:   Strobes are one-cycle pulses
`timescale 1ns/10ps
interface lsd_link_if;
    logic       byte_stb;
    logic [7:0] byte_data;
    logic       cs_rise;
    logic       osc_run;
    logic [9:0] frame_div;
    logic       frame_tick;
    modport rx  (output byte_stb, output byte_data, output cs_rise);
    modport tmr (input osc_run, input frame_div, output frame_tick);
    modport dec (input byte_stb, input byte_data, input cs_rise,
                 input frame_tick, output osc_run, output frame_div);
endinterface

// ---- lsd_pkg.sv ----
// Purpose: Shared constants for the LCD segment driver command decoder
// Assumes: 25 MHz system clock, 20.48 kHz nominal oscillator
// Notes:   Commands and parameters are byte wide
package lsd_pkg;
    localparam logic [7:0] OP_DRIVE_MODE  = 8'h81;
    localparam logic [7:0] OP_DUTY_FRAME  = 8'h82;
    localparam logic [7:0] OP_DISP_ADDR   = 8'h83;
    localparam logic [7:0] OP_BLINK_RATE  = 8'h84;
    localparam logic [7:0] OP_BLINK_ADDR  = 8'h87;
    localparam logic [7:0] OP_GPO_ASSIGN  = 8'h88;
    localparam logic [7:0] OP_LED_ASSIGN  = 8'h89;
    localparam logic [7:0] OP_SOFT_RESET  = 8'h92;
    localparam logic [7:0] OP_RAM_WRITE   = 8'hA0;
    localparam logic [7:0] OP_BLINK_WRITE = 8'hC0;
    // General-output data opcode value is arbitrary
    localparam logic [7:0] OP_GPO_DATA    = 8'h8C;

    localparam logic [7:0] RST_MODE  = 8'h00;
    localparam logic [7:0] RST_DUTY  = 8'h02;
    localparam logic [7:0] RST_ZERO  = 8'h00;

    localparam int DC_BIT       = 7;
    localparam int MODE_ON_BIT  = 3;
    localparam int MODE_INV_BIT = 2;
    localparam int BLINK_EN_BIT = 2;
    localparam int RES8_BIT     = 2;

    localparam logic [5:0] ADDR_LAST  = 6'h30;
    localparam logic [5:0] ADDR_DUMMY = 6'h31;
    localparam logic [5:0] ADDR_FIRST = 6'h00;

    localparam logic [1:0] DUTY_QUARTER = 2'b00;
    localparam logic [1:0] DUTY_THIRD   = 2'b01;

    localparam logic [9:0] DIV_Q0 = 10'd160;
    localparam logic [9:0] DIV_Q1 = 10'd240;
    localparam logic [9:0] DIV_Q2 = 10'd320;
    localparam logic [9:0] DIV_Q3 = 10'd400;
    localparam logic [9:0] DIV_T0 = 10'd156;
    localparam logic [9:0] DIV_T1 = 10'd237;
    localparam logic [9:0] DIV_T2 = 10'd315;
    localparam logic [9:0] DIV_T3 = 10'd393;
    localparam logic [9:0] DIV_S0 = 10'd160;
    localparam logic [9:0] DIV_S1 = 10'd320;
    localparam logic [9:0] DIV_S2 = 10'd428;
    localparam logic [9:0] DIV_S3 = 10'd640;

    localparam int CLK_HZ  = 25000000;
    localparam int OSC_HZ  = 20480;
    localparam int OSC_CYC = CLK_HZ / OSC_HZ;

    localparam int GPO_PINS = 31;
    localparam int LED_PINS = 3;

    typedef enum logic [1:0] {
        DEC_IDLE  = 2'b00,
        DEC_PARAM = 2'b01,
        DEC_DATA  = 2'b10
    } lsd_dec_t;
endpackage

// ---- lsd_serial_rx.sv ----
// Purpose: Three-wire serial receiver, MSB first, one byte per strobe
// Assumes: Pins are asynchronous; serial clock well below system clock
// Notes:   A pin value counts once its second and third stages agree
`timescale 1ns/10ps
module lsd_serial_rx (
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    input  wire logic chip_select_n_in,
    input  wire logic serial_clock_in,
    input  wire logic serial_input_in,
    lsd_link_if.rx    lk
);
    typedef struct packed {
        logic [2:0] cs;
        logic       cs_f;
        logic [2:0] sc;
        logic       sc_f;
        logic [2:0] sd;
        logic       sd_f;
        logic [7:0] sh;
        logic [2:0] cnt;
        logic       stb;
        logic [7:0] dat;
        logic       rise;
    } lsd_rx_t;

    localparam lsd_rx_t RX_RST = '{cs: 3'h7, cs_f: 1'b1, default: '0};

    lsd_rx_t r;
    lsd_rx_t next_r;

    always_comb begin
        next_r = r;
        next_r.cs = {r.cs[1:0], chip_select_n_in};
        next_r.sc = {r.sc[1:0], serial_clock_in};
        next_r.sd = {r.sd[1:0], serial_input_in};
        if (r.cs[1] == r.cs[2]) next_r.cs_f = r.cs[2];
        if (r.sc[1] == r.sc[2]) next_r.sc_f = r.sc[2];
        if (r.sd[1] == r.sd[2]) next_r.sd_f = r.sd[2];
        next_r.stb  = 1'b0;
        next_r.rise = r.cs_f == 1'b0 && next_r.cs_f == 1'b1;
        if (next_r.cs_f) begin
            next_r.cnt = 3'h0;
        end else if (!r.sc_f && next_r.sc_f) begin
            next_r.sh  = {r.sh[6:0], next_r.sd_f};
            next_r.cnt = r.cnt + 3'h1;
            if (r.cnt == 3'h7) begin
                next_r.stb = 1'b1;
                next_r.dat = {r.sh[6:0], next_r.sd_f};
            end
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) r <= RX_RST;
        else            r <= next_r;
    end

    assign lk.byte_stb  = r.stb;
    assign lk.byte_data = r.dat;
    assign lk.cs_rise   = r.rise;
endmodule
